/* File: pkg/fcd_pkg.sv */
// Purpose: shared constants for the flash driver register bank and its host controller
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes on behaviour
// - host clears mode, enable, torch before 5V mode
// - codes 00h-7Fh give 2ms steps, 2..256ms
// - codes 80h+ give (code-127)*8+256 ms
// - mode 00 shutdown unless torch config 10
// - indicator uses six low bits, PWM 31.25kHz
// - assist uses seven low current bits
// - flash uses full setting, auto-clears enable, mode
// - host writes zero to control bit 2
// - control bit 3 gates the current sinks; external torch (mode 00, mask high) runs with it clear
// - trigger bit 6: edge or level sensing
// - trigger bit 7 enables flash trigger input
// - fault flags sticky, cleared by reading
// - fault bit layout, bits 1-2 read zero
// - PWM duty field gives 1/16 to 4/16
// - frequency lock fixes converter at 40h and above, assist and flash only
// - lowest current includes supply, not mask, reductions
// - lowest current only set on real reduction
// - host reads lowest current after flash ends
// - present current shows applied sink current
// - host reads present current twice, compares
// - host writes zero to undefined bits
// - external torch: mask high, mode 00, 7 bits
// - mask config 01 reduces flash current on mask
// - current code is combined current of both sinks

package fcd_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int unsigned PWM_HZ = 31_250;
    localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
    localparam int unsigned PWM_SLOTS = 16;
    localparam int unsigned PWM_SLOT_CYC = PWM_PERIOD_CYC / PWM_SLOTS;

    // ---------------------------------------------------------------
    // device register offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] OFS_IDENT = 4'h0;
    localparam logic [3:0] OFS_CURRENT = 4'h1;
    localparam logic [3:0] OFS_MASK = 4'h3;
    localparam logic [3:0] OFS_SUPPLY = 4'h4;
    localparam logic [3:0] OFS_DURATION = 4'h5;
    localparam logic [3:0] OFS_CTRL = 4'h6;
    localparam logic [3:0] OFS_TRIG = 4'h7;
    localparam logic [3:0] OFS_FAULT = 4'h8;
    localparam logic [3:0] OFS_PWM = 4'h9;
    localparam logic [3:0] OFS_LOWEST = 4'he;
    localparam logic [3:0] OFS_PRESENT = 4'hf;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_CURRENT = 8'h9c;
    localparam logic [7:0] RST_MASK = 8'h68;
    localparam logic [7:0] RST_SUPPLY = 8'h2c;
    localparam logic [7:0] RST_DURATION = 8'h23;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_TRIG = 8'hc0;
    localparam logic [7:0] RST_FAULT = 8'h00;
    localparam logic [7:0] RST_PWM = 8'h00;
    localparam logic [7:0] RST_MEAS = 8'h00;

    // ---------------------------------------------------------------
    // field positions and codes
    // ---------------------------------------------------------------
    localparam int unsigned CTRL_OUT_ON = 3;
    localparam logic [7:0] CTRL_WR_MASK = 8'h0b;
    localparam int unsigned TRIG_LEVEL = 6;
    localparam int unsigned TRIG_ENABLE = 7;
    localparam int unsigned SUPPLY_CONST_V = 7;
    localparam int unsigned PWM_FREQ_LOCK = 2;
    localparam int unsigned FLT_UVLO = 0;
    localparam int unsigned FLT_MASK = 3;
    localparam int unsigned FLT_TIMEOUT = 4;
    localparam int unsigned FLT_OVERTEMP = 5;
    localparam int unsigned FLT_SHORT = 6;
    localparam int unsigned FLT_OVP = 7;
    localparam logic [1:0] MODE_OFF = 2'b00;
    localparam logic [1:0] MODE_INDICATOR = 2'b01;
    localparam logic [1:0] MODE_ASSIST = 2'b10;
    localparam logic [1:0] MODE_FLASH = 2'b11;
    localparam logic [1:0] TORCH_MASK = 2'b01;
    localparam logic [1:0] TORCH_EXT = 2'b10;
    localparam logic [7:0] FREQ_LOCK_MIN = 8'h40;
    localparam logic [7:0] DUR_LONG_CODE = 8'h80;
    localparam logic [10:0] DUR_LONG_SUB = 11'd760; // 127*8 - 256

    // ---------------------------------------------------------------
    // host controller registers (wishbone byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] HOFS_CMD = 8'h00;
    localparam logic [7:0] HOFS_STATUS = 8'h04;
    localparam int unsigned HSTAT_BUSY = 8;

    typedef enum logic [1:0] {
        FL_IDLE = 2'b01,
        FL_ON = 2'b10
    } fcd_flash_t;
endpackage

/* File: pkg/fcd_if.sv */
// Purpose: register access link between host controller and flash driver
// Assumes: both ends on one clock
// Notes: request held until ack; ack is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface fcd_if;
    logic req;
    logic we;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;

    modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
    modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

/* File: hdl/fcd_device.sv */
// Purpose: flash driver control and status register bank with flash sequencing
// Assumes: trigger and mask pins asynchronous; analog status inputs on clk_i
// Notes: register link answers one cycle after a request
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module fcd_device #(
    parameter int unsigned MS_CYC = fcd_pkg::CYC_PER_MS,
    parameter logic [4:0] ID_FIXED = 5'h0a, // arbitrary value
    parameter logic [2:0] ID_VERSION = 3'h1 // arbitrary value
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register link
    fcd_if.dev bus,
    // pins from outside
    input wire logic trigger_i,
    input wire logic mask_pin_i,
    // analog status
    input wire logic uvlo_evt_i,
    input wire logic overtemp_evt_i,
    input wire logic led_short_evt_i,
    input wire logic ovp_evt_i,
    input wire logic uvlo_reduce_i,
    input wire logic [7:0] applied_current_i,
    // analog controls
    output logic [7:0] sink_code_o,
    output logic sink_en_o,
    output logic pwm_o,
    output logic fixed_freq_o,
    output logic mask_active_o,
    output logic [3:0] mask_current_o,
    output logic const_v_o,
    output logic flash_on_o
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] pin_raw;
    logic [2:0] sync_q [2];
    logic [1:0] pin_q;
    assign pin_raw = {mask_pin_i, trigger_i};

    // three flops; the filtered level moves only once stages two and three agree
    for (genvar g = 0; g < 2; g++) begin : g_sync
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                sync_q[g] <= 3'h0;
                pin_q[g] <= 1'b0;
            end else begin
                sync_q[g] <= {sync_q[g][1:0], pin_raw[g]};
                if (sync_q[g][1] == sync_q[g][2]) begin
                    pin_q[g] <= sync_q[g][2];
                end
            end
        end
    end

    logic trig_s, mask_s, trig_prev_q;
    assign trig_s = pin_q[0];
    assign mask_s = pin_q[1];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_s;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] cur_q, mask_q, supply_q, dur_q, ctrl_q, trig_q, fault_q, pwm_q;
    logic [7:0] lowest_q, present_q;
    logic wr, rd, flash_end;
    logic [1:0] mode;
    logic out_on, const_v;
    assign wr = bus.req && !bus.ack && bus.we;
    assign rd = bus.req && !bus.ack && !bus.we;
    assign mode = ctrl_q[1:0];
    assign out_on = ctrl_q[fcd_pkg::CTRL_OUT_ON];
    assign const_v = supply_q[fcd_pkg::SUPPLY_CONST_V];

    // plain read/write settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_q <= fcd_pkg::RST_CURRENT;
            mask_q <= fcd_pkg::RST_MASK;
            supply_q <= fcd_pkg::RST_SUPPLY;
            dur_q <= fcd_pkg::RST_DURATION;
            trig_q <= fcd_pkg::RST_TRIG;
            pwm_q <= fcd_pkg::RST_PWM;
        end else if (wr) begin
            if (bus.addr == fcd_pkg::OFS_CURRENT) cur_q <= bus.wdata;
            if (bus.addr == fcd_pkg::OFS_MASK) mask_q <= bus.wdata;
            if (bus.addr == fcd_pkg::OFS_SUPPLY) supply_q <= bus.wdata;
            if (bus.addr == fcd_pkg::OFS_DURATION) dur_q <= bus.wdata;
            if (bus.addr == fcd_pkg::OFS_TRIG) trig_q <= {bus.wdata[7:6], 6'h00};
            if (bus.addr == fcd_pkg::OFS_PWM) pwm_q <= {5'h00, bus.wdata[2:0]};
        end
    end

    // control: end of flash clears enable and mode; a host write the same cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= fcd_pkg::RST_CTRL;
        end else if (wr && bus.addr == fcd_pkg::OFS_CTRL) begin
            ctrl_q <= bus.wdata & fcd_pkg::CTRL_WR_MASK; // bit 2 and 7:4 kept zero
        end else if (flash_end) begin
            ctrl_q <= fcd_pkg::RST_CTRL;
        end
    end

    // ---------------------------------------------------------------
    // register link answer
    // ---------------------------------------------------------------
    logic [7:0] rmux;
    always_comb begin
        unique case (bus.addr)
            fcd_pkg::OFS_IDENT: rmux = {ID_FIXED, ID_VERSION};
            fcd_pkg::OFS_CURRENT: rmux = cur_q;
            fcd_pkg::OFS_MASK: rmux = mask_q;
            fcd_pkg::OFS_SUPPLY: rmux = supply_q;
            fcd_pkg::OFS_DURATION: rmux = dur_q;
            fcd_pkg::OFS_CTRL: rmux = ctrl_q;
            fcd_pkg::OFS_TRIG: rmux = trig_q;
            fcd_pkg::OFS_FAULT: rmux = fault_q;
            fcd_pkg::OFS_PWM: rmux = pwm_q;
            fcd_pkg::OFS_LOWEST: rmux = lowest_q;
            fcd_pkg::OFS_PRESENT: rmux = present_q;
            default: rmux = 8'h00; // unmapped offsets read zero
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus.ack <= 1'b0;
            bus.rdata <= 8'h00;
        end else begin
            bus.ack <= bus.req && !bus.ack;
            if (rd) bus.rdata <= rmux;
        end
    end

    // ---------------------------------------------------------------
    // flash sequencing
    // ---------------------------------------------------------------
    fcd_pkg::fcd_flash_t fl_q;
    logic [16:0] pre_q;
    logic [10:0] ms_q, limit_ms;
    logic flash_armed, trig_en, trig_level, start, expire, lvl_drop;
    assign flash_armed = mode == fcd_pkg::MODE_FLASH && out_on && !const_v;
    assign trig_en = trig_q[fcd_pkg::TRIG_ENABLE];
    assign trig_level = trig_q[fcd_pkg::TRIG_LEVEL];

    // duration code to milliseconds
    always_comb begin
        if (dur_q < fcd_pkg::DUR_LONG_CODE) begin
            limit_ms = {2'b00, dur_q, 1'b0} + 11'd2;
        end else begin
            limit_ms = {dur_q, 3'b000} - fcd_pkg::DUR_LONG_SUB;
        end
    end

    // a disabled trigger fires the flash as soon as it is armed
    assign start = flash_armed && (!trig_en || (trig_level ? trig_s : (trig_s && !trig_prev_q)));
    // end on the last cycle of the final millisecond so the pulse lasts exactly the limit
    assign expire = (ms_q + 11'h001 >= limit_ms) && pre_q == 17'(MS_CYC - 1);
    assign lvl_drop = trig_en && trig_level && !trig_s;
    assign flash_end = fl_q == fcd_pkg::FL_ON && (expire || lvl_drop);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fl_q <= fcd_pkg::FL_IDLE;
            pre_q <= 17'h00000;
            ms_q <= 11'h000;
        end else begin
            unique case (fl_q)
                fcd_pkg::FL_IDLE: begin
                    pre_q <= 17'h00000;
                    ms_q <= 11'h000;
                    if (start) fl_q <= fcd_pkg::FL_ON;
                end
                fcd_pkg::FL_ON: begin
                    if (flash_end || !flash_armed) begin
                        fl_q <= fcd_pkg::FL_IDLE;
                    end else if (pre_q == 17'(MS_CYC - 1)) begin
                        pre_q <= 17'h00000;
                        ms_q <= ms_q + 11'h001;
                    end else begin
                        pre_q <= pre_q + 17'h00001;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // fault flags: set beats the read that clears
    // ---------------------------------------------------------------
    logic flashing, mask_reduce;
    logic [7:0] fault_set;
    assign flashing = fl_q == fcd_pkg::FL_ON;
    assign mask_reduce = flashing && mask_s && mask_q[1:0] == fcd_pkg::TORCH_MASK;
    always_comb begin
        fault_set = 8'h00;
        fault_set[fcd_pkg::FLT_UVLO] = uvlo_evt_i;
        fault_set[fcd_pkg::FLT_MASK] = mask_reduce;
        fault_set[fcd_pkg::FLT_TIMEOUT] = flashing && expire && !lvl_drop && trig_en && trig_level;
        fault_set[fcd_pkg::FLT_OVERTEMP] = overtemp_evt_i;
        fault_set[fcd_pkg::FLT_SHORT] = led_short_evt_i;
        fault_set[fcd_pkg::FLT_OVP] = ovp_evt_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= fcd_pkg::RST_FAULT;
        end else if (rd && bus.addr == fcd_pkg::OFS_FAULT) begin
            fault_q <= fault_set;
        end else begin
            fault_q <= fault_q | fault_set;
        end
    end

    // ---------------------------------------------------------------
    // sink control
    // ---------------------------------------------------------------
    logic ext_torch, run;
    logic [7:0] code;
    assign ext_torch = mode == fcd_pkg::MODE_OFF && mask_q[1:0] == fcd_pkg::TORCH_EXT && mask_s;
    assign run = !const_v && ((out_on && (mode == fcd_pkg::MODE_INDICATOR
        || mode == fcd_pkg::MODE_ASSIST || flashing)) || ext_torch);

    // code is the combined current of both sinks
    always_comb begin
        unique case (mode)
            fcd_pkg::MODE_INDICATOR: code = {2'b00, cur_q[5:0]};
            fcd_pkg::MODE_ASSIST: code = {1'b0, cur_q[6:0]};
            fcd_pkg::MODE_FLASH: code = cur_q;
            fcd_pkg::MODE_OFF: code = {1'b0, cur_q[6:0]};
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sink_code_o <= 8'h00;
            sink_en_o <= 1'b0;
            fixed_freq_o <= 1'b0;
            mask_active_o <= 1'b0;
            mask_current_o <= 4'h0;
            const_v_o <= 1'b0;
            flash_on_o <= 1'b0;
        end else begin
            sink_code_o <= run ? code : 8'h00;
            sink_en_o <= run;
            fixed_freq_o <= run && pwm_q[fcd_pkg::PWM_FREQ_LOCK] && mode[1]
                && code >= fcd_pkg::FREQ_LOCK_MIN;
            mask_active_o <= mask_reduce;
            mask_current_o <= mask_q[7:4];
            const_v_o <= const_v;
            flash_on_o <= flashing;
        end
    end

    // ---------------------------------------------------------------
    // indicator PWM: 16 slots per period, duty (field+1)/16
    // ---------------------------------------------------------------
    logic [7:0] slot_cnt_q;
    logic [3:0] phase_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_cnt_q <= 8'h00;
            phase_q <= 4'h0;
            pwm_o <= 1'b0;
        end else begin
            if (slot_cnt_q == 8'(fcd_pkg::PWM_SLOT_CYC - 1)) begin
                slot_cnt_q <= 8'h00;
                phase_q <= phase_q + 4'h1;
            end else begin
                slot_cnt_q <= slot_cnt_q + 8'h01;
            end
            pwm_o <= run && mode == fcd_pkg::MODE_INDICATOR
                && phase_q <= {2'b00, pwm_q[1:0]};
        end
    end

    // ---------------------------------------------------------------
    // current monitors
    // ---------------------------------------------------------------
    logic run_prev_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            present_q <= fcd_pkg::RST_MEAS;
            lowest_q <= fcd_pkg::RST_MEAS;
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run;
            present_q <= applied_current_i;
            if (run && !run_prev_q) begin
                lowest_q <= fcd_pkg::RST_MEAS; // new operation cycle
            end else if (run && uvlo_reduce_i && !mask_reduce
                && (lowest_q == 8'h00 || applied_current_i < lowest_q)) begin
                lowest_q <= applied_current_i;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/fcd_host.sv */
// Purpose: host controller turning wishbone commands into register link transfers
// Assumes: classic wishbone slave, 32-bit data, one clock
// Notes: a command written while busy is dropped; poll the busy bit
`timescale 1ns/10ps
`default_nettype none
module fcd_host (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // register link
    fcd_if.host link
);
    // ---------------------------------------------------------------
    // wishbone access
    // ---------------------------------------------------------------
    logic acc, cmd_wr;
    logic [7:0] rdata_q;
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // lane 2 carries the direction and launches the transfer
    assign cmd_wr = acc && wb_we_i && wb_adr_i == fcd_pkg::HOFS_CMD && wb_sel_i[2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= acc;
            if (acc && !wb_we_i) begin
                if (wb_adr_i == fcd_pkg::HOFS_STATUS) begin
                    wb_dat_o <= {23'h000000, link.req, rdata_q};
                end else if (wb_adr_i == fcd_pkg::HOFS_CMD) begin
                    wb_dat_o <= {15'h0000, link.we, 4'h0, link.addr, link.wdata};
                end else begin
                    wb_dat_o <= 32'h00000000;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // register link master: request held until the device acks
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.req <= 1'b0;
            link.we <= 1'b0;
            link.addr <= 4'h0;
            link.wdata <= 8'h00;
            rdata_q <= 8'h00;
        end else if (link.req) begin
            if (link.ack) begin
                link.req <= 1'b0;
                if (!link.we) rdata_q <= link.rdata;
            end
        end else begin
            if (acc && wb_we_i && wb_adr_i == fcd_pkg::HOFS_CMD) begin
                if (wb_sel_i[0]) link.wdata <= wb_dat_i[7:0];
                if (wb_sel_i[1]) link.addr <= wb_dat_i[11:8];
            end
            if (cmd_wr) begin
                link.we <= wb_dat_i[16];
                link.req <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/fcd_link_checker.sv */
// Purpose: link checks between host controller and device
// Assumes: one clock, synchronous active-high reset
// Notes: shadows hold written config so reads can be judged
`timescale 1ns/10ps
`default_nettype none
module fcd_link_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register link
    input wire logic req,
    input wire logic we,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    logic [7:0] dur_q;
    logic [7:0] trig_q;
    logic rd;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a read answer is an ack on a non-write
    assign rd = ack && !we;
    // shadows track writes, since only writes may move these fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dur_q <= fcd_pkg::RST_DURATION;
            trig_q <= fcd_pkg::RST_TRIG;
        end else if (ack && we) begin
            if (addr == fcd_pkg::OFS_DURATION) dur_q <= wdata;
            if (addr == fcd_pkg::OFS_TRIG) trig_q <= wdata & 8'hc0;
        end
    end
    property p_ack_follows; req && !ack |=> ack; endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("no ack");
    property p_ack_single; ack |=> !ack; endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack too long");
    property p_rdata_hold; $changed(rdata) |-> rd; endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
    property p_fault_gap; rd && addr == fcd_pkg::OFS_FAULT |-> rdata[2:1] == 2'h0; endproperty
    a_fault_gap: assert property (p_fault_gap) else $error("fault gap bits");
    property p_ctrl_bits; rd && addr == fcd_pkg::OFS_CTRL |-> (rdata & 8'hf4) == 8'h00; endproperty
    a_ctrl_bits: assert property (p_ctrl_bits) else $error("ctrl bits");
    property p_trig_read; rd && addr == fcd_pkg::OFS_TRIG |-> rdata == trig_q; endproperty
    a_trig_read: assert property (p_trig_read) else $error("trig value");
    property p_pwm_read; rd && addr == fcd_pkg::OFS_PWM |-> rdata[7:3] == 5'h00; endproperty
    a_pwm_read: assert property (p_pwm_read) else $error("pwm bits");
    property p_dur_read; rd && addr == fcd_pkg::OFS_DURATION |-> rdata == dur_q; endproperty
    a_dur_read: assert property (p_dur_read) else $error("duration value");
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: end-to-end bench, wishbone to host to device
// Assumes: 125 MHz clock, one ms shortened to 10 cycles
// Notes: every link transfer is a command plus status polling
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int MSC = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0;
    logic [31:0] dr;
    logic ack;
    logic [3:0] evt = 4'h0;
    logic ured = 1'b0;
    logic [7:0] appl = 8'h44;
    logic [7:0] code;
    logic en;
    logic pwm;
    logic fon;
    logic [7:0] rv;
    logic [7:0] cd;
    logic [31:0] cnt;
    logic [31:0] on_cnt = 32'h0;
    logic [31:0] on_base;
    logic [7:0] rst_tab [16] = '{8'h51, 8'h9c, 8'h00, 8'h68, 8'h2c, 8'h23, 8'h00, 8'hc0,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h44};
    int error_cnt = 0;
    int n_compared = 0;
    fcd_if lnk ();
    always #4 clk_i = ~clk_i;
    // flash length is counted apart from the polling traffic
    always @(posedge clk_i) if (fon === 1'b1) on_cnt <= on_cnt + 1;
    fcd_host fcd_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .link(lnk.host));
    fcd_device #(.MS_CYC(MSC)) fcd_device_i (.clk_i(clk_i), .rst_i(rst_i), .bus(lnk.dev),
        .trigger_i(1'b0), .mask_pin_i(1'b0), .uvlo_evt_i(evt[0]), .overtemp_evt_i(evt[1]),
        .led_short_evt_i(evt[2]), .ovp_evt_i(evt[3]), .uvlo_reduce_i(ured),
        .applied_current_i(appl), .sink_code_o(code), .sink_en_o(en), .pwm_o(pwm),
        .fixed_freq_o(), .mask_active_o(), .mask_current_o(), .const_v_o(),
        .flash_on_o(fon));
    fcd_link_checker fcd_link_checker_i (.clk_i(clk_i), .rst_i(rst_i), .req(lnk.req),
        .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
    endtask
    task automatic dev(input logic w, input logic [3:0] a, input logic [7:0] d);
        wb(1'b1, fcd_pkg::HOFS_CMD, {15'h0, w, 4'h0, a, d});
        do wb(1'b0, fcd_pkg::HOFS_STATUS, 32'h0); while (dr[fcd_pkg::HSTAT_BUSY] !== 1'b0);
        rv = dr[7:0];
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        dev(1'b0, a, 8'h00);
        chk(nm, e, rv);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watchdog: the tests need about 35000 cycles
    initial begin
        repeat (100000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 16; i++) rd(i[3:0], rst_tab[i], "reset value");
        $display("reset values done");
        dev(1'b1, fcd_pkg::OFS_TRIG, 8'hff);
        rd(fcd_pkg::OFS_TRIG, 8'hc0, "trig");
        dev(1'b1, fcd_pkg::OFS_CTRL, 8'hf6);
        rd(fcd_pkg::OFS_CTRL, 8'h02, "ctrl");
        chk("sinks off", 1'b0, en);
        dev(1'b1, fcd_pkg::OFS_CTRL, 8'h0a);
        chk("assist code", 8'h1c, code);
        chk("sinks on", 1'b1, en);
        dev(1'b1, fcd_pkg::OFS_CTRL, 8'h09);
        chk("indicator code", 8'h1c, code);
        // settle a full period after each duty change before counting
        for (int d = 0; d < 4; d++) begin
            dev(1'b1, fcd_pkg::OFS_PWM, d[7:0]);
            repeat (4000) @(posedge clk_i);
            cnt = 32'h0;
            repeat (4000) @(posedge clk_i) cnt = cnt + pwm;
            chk("pwm high", (d + 1) * 250, cnt);
        end
        dev(1'b1, fcd_pkg::OFS_CTRL, 8'h00);
        chk("shutdown", 1'b0, en);
        $display("modes done");
        dev(1'b1, fcd_pkg::OFS_TRIG, 8'h00);
        for (int i = 0; i < 3; i++) begin
            cd = (i == 2) ? 8'h80 : i[7:0];
            ured <= (i == 1);
            dev(1'b1, fcd_pkg::OFS_DURATION, cd);
            on_base = on_cnt;
            dev(1'b1, fcd_pkg::OFS_CTRL, 8'h0b);
            if (i == 2) chk("flash code", 8'h9c, code);
            while (fon === 1'b1) @(posedge clk_i);
            repeat (2) @(posedge clk_i);
            cnt = MSC * ((cd < 8'h80) ? 2 * (cd + 1) : (cd - 127) * 8 + 256);
            chk("flash length", cnt, on_cnt - on_base);
            rd(fcd_pkg::OFS_CTRL, 8'h00, "ctrl cleared");
            rd(fcd_pkg::OFS_LOWEST, (i == 1) ? 8'h44 : 8'h00, "lowest");
        end
        $display("flash done");
        evt <= 4'hf;
        @(posedge clk_i);
        evt <= 4'h0;
        rd(fcd_pkg::OFS_FAULT, 8'he1, "fault set");
        rd(fcd_pkg::OFS_FAULT, 8'h00, "fault cleared");
        appl <= 8'h21;
        rd(fcd_pkg::OFS_PRESENT, 8'h21, "present");
        $display("faults done");
        give_verdict();
    end
endmodule
`default_nettype wire
